//--- include/gfs_consts.vh
// gas sensor fault supervisor: shared constants as macros.
// assumes: 125 MHz system clock, loop codes in mA x100, temperature in
// whole degrees C, supply in V x100, concentration in whole % LEL.
`ifndef GFS_CONSTS_VH
`define GFS_CONSTS_VH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define GFS_CLK_MHZ 125
`define GFS_SEC_S 1
`define GFS_SEC_CYC 27'h7735940
`define GFS_HOLD_S 1
`define GFS_MIN_SEC 17'h0003c
`define GFS_DAY_SEC 17'h15180
`define GFS_MSG_SEC 4'h5
`define GFS_REMIND_DAYS 16'h00b4

// ----------------------------------------------------------------------
// fault status word bit positions
// ----------------------------------------------------------------------
`define GFS_B_GLOBAL 0
`define GFS_B_REMIND 1
`define GFS_B_TEMP 2
`define GFS_B_LOOP 3
`define GFS_B_SUPPLY 4
`define GFS_B_MEM 5
`define GFS_B_PROC 6
`define GFS_B_CLEAR 7
`define GFS_B_STAB 8
`define GFS_B_RANGE 9
`define GFS_B_DET 10
`define GFS_B_ZERO 11
`define GFS_B_DET2 12
`define GFS_B_INCAL 14
`define GFS_STAT_RST 16'h0000

// ----------------------------------------------------------------------
// loop output codes, mA x100
// ----------------------------------------------------------------------
`define GFS_LOOP_FAULT 16'h0000
`define GFS_LOOP_CAL 16'h00c8
`define GFS_LOOP_OVER 16'h0898
`define GFS_LOOP_ZERO_SCALE 16'h0190
`define GFS_LOOP_SPAN 16'h0640

// ----------------------------------------------------------------------
// limits
// ----------------------------------------------------------------------
`define GFS_ZERO_LIM 16'hfff6
`define GFS_SUP_MIN 16'h047e
`define GFS_SUP_MAX 16'h0af0
`define GFS_TEMP_MIN 16'hffd8
`define GFS_TEMP_MAX 16'h004b
`define GFS_LIFE_MAX 8'h64

// ----------------------------------------------------------------------
// display modes
// ----------------------------------------------------------------------
`define GFS_DISP_NORM 2'h0
`define GFS_DISP_MSG 2'h1
`define GFS_DISP_LIST 2'h2

`endif

//--- rtl/gfs_supervisor.v
// fault supervision and loop output level selection for a gas detector.
// assumes: measurement, supply, temperature and health inputs come from
// logic on i_clk; only the magnet switch arrives from a pin.
`timescale 1ns/10ps
`default_nettype none
`include "gfs_consts.vh"

// What this block does
// - over full scale, flash full-scale reading and drive 22 mA.
// - during zero or span calibration drive 2.0 mA and set bit 14.
// - recompute remaining life 0 to 100 percent after each span.
// - count whole days since the last good span; restart on a good span.
// - with any fault active and no calibration running, show fault message once per minute.
// - magnet switch held 1 s during the message lists every fault.
// - cal, bridge, detector, processor, memory, loop, supply faults: 0 mA.
// - temperature and reminder faults leave the loop reporting normally.
// - each fault has its own status bit; health, supply, temperature and reminder bits follow their cause, zero/range/stability/clearing bits latch.
// - reading below -10 % LEL latches zero fault, 0 mA, until good zero.
// - too small span change latches range fault until a good span.
// - failed stability test latches stability fault until a good span.
// - failed clearing test latches clearing fault until a good span.
// - open or missing detector element gives detector fault and 0 mA.
// - unrecoverable run-time error gives processor fault and 0 mA.
// - failed nonvolatile write gives memory fault and 0 mA.
// - broken current loop gives loop fault and 0 mA.
// - supply outside 11.5 to 28 V gives supply fault and 0 mA.
// - temperature outside -40 to +75 C gives temperature fault only.
// - at 180 days since span, raise the calibration reminder fault.
// - status word has one bit per fault, 0x0002 to 0x1000, 0x0001 set with any of them, calibration 0x4000.
module gfs_supervisor #(
   parameter [26:0] P_SEC_CYC = `GFS_SEC_CYC,
   parameter [16:0] P_DAY_SEC = `GFS_DAY_SEC,
   parameter [16:0] P_MIN_SEC = `GFS_MIN_SEC
) (
   // clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // measurement
   input wire signed [15:0] i_conc,
   input wire [15:0] i_full_scale,
   input wire [15:0] i_supply_cv,
   input wire signed [15:0] i_temp_c,
   // health conditions
   input wire i_det_open,
   input wire i_bridge_fail,
   input wire i_proc_err,
   input wire i_mem_wr_fail,
   input wire i_loop_fail,
   // calibration events
   input wire i_cal_zero_busy,
   input wire i_cal_span_busy,
   input wire i_zero_ok,
   input wire i_span_ok,
   input wire i_span_range_fail,
   input wire i_span_stab_fail,
   input wire i_span_clear_fail,
   input wire [15:0] i_span_gain,
   input wire [15:0] i_span_gain_ref,
   // magnet switch pin
   input wire i_second_magnet_switch,
   // status and serial values
   output reg [15:0] o_fault_status,
   output reg [7:0] o_life_pct,
   output reg [15:0] o_days_since_span,
   output reg [15:0] o_loop_code,
   // display
   output reg o_disp_flash_fs,
   output reg [1:0] o_disp_mode,
   output reg [3:0] o_disp_fault_idx
);

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   // next set fault bit above a given index, zero when none left
   function [3:0] gfs_next_bit;
      input [15:0] st;
      input [3:0] from;
      integer i;
      begin
         gfs_next_bit = 4'h0;
         for (i = `GFS_B_DET2; i >= 1; i = i - 1) begin
            if (st[i] && (i > from))
               gfs_next_bit = i[3:0];
         end
      end
   endfunction

   // -------------------------------------------------------------------
   // magnet switch synchroniser
   // -------------------------------------------------------------------
   reg mag_s1_r;
   reg mag_s2_r;

   // two flops before any logic reads the pin
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mag_s1_r <= 1'b0;
         mag_s2_r <= 1'b0;
      end else begin
         mag_s1_r <= i_second_magnet_switch;
         mag_s2_r <= mag_s1_r;
      end
   end

   // -------------------------------------------------------------------
   // time base: seconds, minutes, days
   // -------------------------------------------------------------------
   reg [26:0] cyc_r;
   reg [16:0] day_sec_r;
   reg [16:0] min_sec_r;
   wire sec_tick = (cyc_r == (P_SEC_CYC - 27'h1));
   wire day_tick = sec_tick && (day_sec_r == (P_DAY_SEC - 17'h1));
   wire min_tick = sec_tick && (min_sec_r == (P_MIN_SEC - 17'h1));

   // one-cycle enables from a free-running divider
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cyc_r <= 27'h0;
         day_sec_r <= 17'h0;
         min_sec_r <= 17'h0;
      end else begin
         cyc_r <= sec_tick ? 27'h0 : cyc_r + 27'h1;
         if (i_span_ok)
            day_sec_r <= 17'h0;
         else if (sec_tick)
            day_sec_r <= day_tick ? 17'h0 : day_sec_r + 17'h1;
         if (sec_tick)
            min_sec_r <= min_tick ? 17'h0 : min_sec_r + 17'h1;
      end
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         o_days_since_span <= 16'h0;
      else if (i_span_ok)
         o_days_since_span <= 16'h0;
      else if (day_tick && (o_days_since_span != 16'hffff))
         o_days_since_span <= o_days_since_span + 16'h1;
   end

   // -------------------------------------------------------------------
   // remaining life
   // -------------------------------------------------------------------
   wire [31:0] life_prod = {16'h0, i_span_gain} * 32'd100;
   wire [31:0] life_q = (i_span_gain_ref == 16'h0) ? 32'h0 :
                        life_prod / {16'h0, i_span_gain_ref};

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         o_life_pct <= `GFS_LIFE_MAX;
      else if (i_span_ok)
         o_life_pct <= (life_q > {24'h0, `GFS_LIFE_MAX}) ?
                       `GFS_LIFE_MAX : life_q[7:0];
   end

   // -------------------------------------------------------------------
   // fault conditions
   // -------------------------------------------------------------------
   wire cal_busy = i_cal_zero_busy | i_cal_span_busy;
   wire zero_drift = (i_conc < $signed(`GFS_ZERO_LIM));
   wire sup_bad = (i_supply_cv < `GFS_SUP_MIN) ||
                  (i_supply_cv > `GFS_SUP_MAX);
   wire temp_bad = (i_temp_c < $signed(`GFS_TEMP_MIN)) ||
                   (i_temp_c > $signed(`GFS_TEMP_MAX));
   wire remind = (o_days_since_span >= `GFS_REMIND_DAYS);
   wire over_range = (i_conc > $signed(i_full_scale));

   reg [15:0] stat_nxt;

   always @* begin
      stat_nxt = o_fault_status;
      stat_nxt[`GFS_B_DET] = i_det_open;
      stat_nxt[`GFS_B_DET2] = i_bridge_fail;
      stat_nxt[`GFS_B_PROC] = i_proc_err;
      stat_nxt[`GFS_B_MEM] = i_mem_wr_fail;
      stat_nxt[`GFS_B_LOOP] = i_loop_fail;
      stat_nxt[`GFS_B_SUPPLY] = sup_bad;
      stat_nxt[`GFS_B_TEMP] = temp_bad;
      stat_nxt[`GFS_B_REMIND] = remind & ~i_span_ok;
      if (zero_drift)
         stat_nxt[`GFS_B_ZERO] = 1'b1;
      else if (i_zero_ok)
         stat_nxt[`GFS_B_ZERO] = 1'b0;
      if (i_span_range_fail)
         stat_nxt[`GFS_B_RANGE] = 1'b1;
      else if (i_span_ok)
         stat_nxt[`GFS_B_RANGE] = 1'b0;
      if (i_span_stab_fail)
         stat_nxt[`GFS_B_STAB] = 1'b1;
      else if (i_span_ok)
         stat_nxt[`GFS_B_STAB] = 1'b0;
      if (i_span_clear_fail)
         stat_nxt[`GFS_B_CLEAR] = 1'b1;
      else if (i_span_ok)
         stat_nxt[`GFS_B_CLEAR] = 1'b0;
      stat_nxt[13] = 1'b0;
      stat_nxt[15] = 1'b0;
      stat_nxt[`GFS_B_INCAL] = cal_busy;
      stat_nxt[`GFS_B_GLOBAL] = |stat_nxt[`GFS_B_DET2:`GFS_B_REMIND];
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         o_fault_status <= `GFS_STAT_RST;
      else
         o_fault_status <= stat_nxt;
   end

   // -------------------------------------------------------------------
   // loop output level
   // -------------------------------------------------------------------
   // faults that drop the loop
   wire drop_fault = |stat_nxt[`GFS_B_DET2:`GFS_B_LOOP]; // temp, remind below
   wire [15:0] conc_pos = i_conc[15] ? 16'h0 : i_conc;
   wire [31:0] span_prod = {16'h0, conc_pos} * {16'h0, `GFS_LOOP_SPAN};
   wire [31:0] span_q = (i_full_scale == 16'h0) ? 32'h0 :
                        span_prod / {16'h0, i_full_scale};
   wire [15:0] norm_code = `GFS_LOOP_ZERO_SCALE + span_q[15:0];
   reg [15:0] loop_nxt;

   always @* begin
      if (drop_fault)
         loop_nxt = `GFS_LOOP_FAULT;
      else if (cal_busy)
         loop_nxt = `GFS_LOOP_CAL;
      else if (over_range)
         loop_nxt = `GFS_LOOP_OVER;
      else
         loop_nxt = norm_code;
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_loop_code <= `GFS_LOOP_FAULT;
         o_disp_flash_fs <= 1'b0;
      end else begin
         o_loop_code <= loop_nxt;
         o_disp_flash_fs <= over_range & ~cal_busy;
      end
   end

   // -------------------------------------------------------------------
   // display fault indication
   // -------------------------------------------------------------------
   reg [26:0] hold_r;
   reg held_r;
   reg [3:0] msg_sec_r;

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hold_r <= 27'h0;
         held_r <= 1'b0;
      end else if (!mag_s2_r || (o_disp_mode != `GFS_DISP_MSG)) begin
         hold_r <= 27'h0;
         held_r <= 1'b0;
      end else if (hold_r == (P_SEC_CYC - 27'h1)) begin
         hold_r <= 27'h0;
         held_r <= 1'b1;
      end else begin
         hold_r <= hold_r + 27'h1;
      end
   end

   wire [3:0] first_bit = gfs_next_bit(o_fault_status, 4'h0);
   wire [3:0] later_bit = gfs_next_bit(o_fault_status, o_disp_fault_idx);
   wire any_fault = o_fault_status[`GFS_B_GLOBAL];

   // display state machine
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_disp_mode <= `GFS_DISP_NORM;
         o_disp_fault_idx <= 4'h0;
         msg_sec_r <= 4'h0;
      end else begin
         case (o_disp_mode)
            `GFS_DISP_NORM: begin
               if (min_tick && any_fault && !cal_busy) begin
                  o_disp_mode <= `GFS_DISP_MSG;
                  msg_sec_r <= 4'h0;
               end
            end
            `GFS_DISP_MSG: begin
               if (held_r && any_fault) begin
                  o_disp_mode <= `GFS_DISP_LIST;
                  o_disp_fault_idx <= first_bit;
               end else if (sec_tick) begin
                  if (msg_sec_r == (`GFS_MSG_SEC - 4'h1))
                     o_disp_mode <= `GFS_DISP_NORM;
                  msg_sec_r <= msg_sec_r + 4'h1;
               end
            end
            `GFS_DISP_LIST: begin
               if (sec_tick) begin
                  o_disp_fault_idx <= later_bit;
                  if (later_bit == 4'h0)
                     o_disp_mode <= `GFS_DISP_NORM;
               end
            end
            default: begin
               o_disp_mode <= `GFS_DISP_NORM;
               o_disp_fault_idx <= 4'h0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

//--- verification/gfs_supervisor_sva.sv
// checker for the gas sensor fault supervisor outputs.
// assumes: bound to gfs_supervisor, one clock, async active-low reset.
`timescale 1ns/10ps
`default_nettype none
module gfs_supervisor_sva (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // watched inputs
   input wire logic signed [15:0] i_conc,
   input wire logic [15:0] i_supply_cv,
   input wire logic signed [15:0] i_temp_c,
   input wire logic i_cal_zero_busy,
   input wire logic i_cal_span_busy,
   input wire logic i_span_ok,
   input wire logic i_span_range_fail,
   // watched outputs
   input wire logic [15:0] o_fault_status,
   input wire logic [7:0] o_life_pct,
   input wire logic [15:0] o_days_since_span,
   input wire logic [15:0] o_loop_code,
   input wire logic o_disp_flash_fs
);
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // latched range fault and its clearing span
   sequence s_range_held;
      o_fault_status[9] && !i_span_ok;
   endsequence
   sequence s_span_done;
      i_span_ok && !i_span_range_fail;
   endsequence
   a_incal_flag: assert property (
      (i_cal_zero_busy || i_cal_span_busy) |=> o_fault_status[14])
      else $error("calibration flag missing");
   a_global_or: assert property (
      o_fault_status[0] == (|o_fault_status[12:1]))
      else $error("global bit wrong");
   a_fault_drop: assert property (
      (|o_fault_status[12:3]) |-> o_loop_code == 16'h0000)
      else $error("fault without zero loop");
   a_over_level: assert property (
      o_disp_flash_fs && !(|o_fault_status[12:3]) |->
      o_loop_code == 16'h0898) else $error("over-range level wrong");
   a_cal_level: assert property (
      o_fault_status[14] && !(|o_fault_status[12:3]) |->
      o_loop_code == 16'h00c8 && !o_disp_flash_fs)
      else $error("calibration level wrong");
   a_zero_drift: assert property (
      i_conc < 16'shfff6 |=> o_fault_status[11] && o_loop_code == 16'h0000)
      else $error("zero fault missing");
   a_supply_win: assert property (
      (i_supply_cv < 16'h047e || i_supply_cv > 16'h0af0) |=>
      o_fault_status[4]) else $error("supply fault missing");
   a_temp_win: assert property (
      (i_temp_c < 16'shffd8 || i_temp_c > 16'sh004b) |=> o_fault_status[2])
      else $error("temperature fault missing");
   a_range_hold: assert property (s_range_held |=> o_fault_status[9])
      else $error("range fault dropped");
   a_span_clear: assert property (
      s_span_done |=> !o_fault_status[9] && o_days_since_span == 16'h0000)
      else $error("span did not restart");
   a_life_scale: assert property (o_life_pct <= 8'h64)
      else $error("life above full scale");
   a_reserved_bits: assert property (
      !o_fault_status[13] && !o_fault_status[15])
      else $error("reserved status bit set");
endmodule
bind gfs_supervisor gfs_supervisor_sva chk_u (.i_clk(i_clk),
   .i_rst_n(i_rst_n), .i_conc(i_conc), .i_supply_cv(i_supply_cv),
   .i_temp_c(i_temp_c), .i_cal_zero_busy(i_cal_zero_busy),
   .i_cal_span_busy(i_cal_span_busy), .i_span_ok(i_span_ok),
   .i_span_range_fail(i_span_range_fail), .o_fault_status(o_fault_status),
   .o_life_pct(o_life_pct), .o_days_since_span(o_days_since_span),
   .o_loop_code(o_loop_code), .o_disp_flash_fs(o_disp_flash_fs));
`default_nettype wire

//--- verification/gfs_loop_rx.sv
// loop receiver and status polling master facing the supervisor.
// assumes: loop code in mA x100, status polled once a clock.
`timescale 1ns/10ps
`default_nettype none
module gfs_loop_rx (
   // device side
   input wire logic i_clk,
   input wire logic [15:0] i_loop_code,
   input wire logic [15:0] i_status,
   // receiver view
   output logic o_fault_lvl,
   output logic [15:0] o_polled
);
   // zero current reads as the fault level
   assign o_fault_lvl = (i_loop_code == 16'h0000);
   // master polls the status word every cycle
   always_ff @(posedge i_clk) begin
      o_polled <= i_status;
   end
endmodule
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the fault supervisor with a loop receiver.
// assumes: shortened second, minute and day counts set below.
`timescale 1ns/10ps
`default_nettype none
`include "gfs_consts.vh"
module tb;
   localparam int DAYC = 80; // cycles a day: 4 seconds of 20 cycles
   logic i_clk, i_rst_n, zb, sb, zok, sok, mag, flash, rx_f;
   logic signed [15:0] conc, temp;
   logic [15:0] fs, sup, gain, gref, st, days, lc, rx_p;
   logic [4:0] hv;
   logic [2:0] pv;
   logic [7:0] life;
   logic [1:0] mode;
   logic [3:0] idx;
   int failures, n_compared;
   int hb[5] = '{3, 5, 6, 12, 10};
   // device under test and far side
   gfs_supervisor #(.P_SEC_CYC(27'd20), .P_DAY_SEC(17'h4), .P_MIN_SEC(17'h3))
   dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_conc(conc),
      .i_full_scale(fs), .i_supply_cv(sup), .i_temp_c(temp),
      .i_det_open(hv[4]), .i_bridge_fail(hv[3]), .i_proc_err(hv[2]),
      .i_mem_wr_fail(hv[1]), .i_loop_fail(hv[0]), .i_cal_zero_busy(zb),
      .i_cal_span_busy(sb), .i_zero_ok(zok), .i_span_ok(sok),
      .i_span_range_fail(pv[2]), .i_span_stab_fail(pv[1]),
      .i_span_clear_fail(pv[0]), .i_span_gain(gain),
      .i_span_gain_ref(gref), .i_second_magnet_switch(mag),
      .o_fault_status(st), .o_life_pct(life), .o_days_since_span(days),
      .o_loop_code(lc), .o_disp_flash_fs(flash), .o_disp_mode(mode),
      .o_disp_fault_idx(idx));
   gfs_loop_rx rx_u (.i_clk(i_clk), .i_loop_code(lc), .i_status(st),
      .o_fault_lvl(rx_f), .o_polled(rx_p));
   // free-running clock
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   task give_verdict;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   // bounded wait on mode, list index or status bits
   task wait_val(input int sel, input logic [15:0] v, input logic [15:0] m);
      int k;
      for (k = 0; k < 400; k++) begin
         if (((sel == 0 ? {14'h0, mode} : sel == 1 ? {12'h0, idx} : st)
            & m) === v) break;
         tick(1);
      end
      if (k == 400) begin
         failures++;
         $display("wrong value at %0t: wait ran out", $time);
         give_verdict();
      end
   endtask
   task do_span(input logic [15:0] g);
      gain = g;
      sok = 1'b1;
      tick(1);
      sok = 1'b0;
      tick(1);
   endtask
   task t_levels;
      conc = 16'sh0078;
      tick(1);
      chk(lc, `GFS_LOOP_OVER);
      chk({15'h0, flash}, 16'h0001);
      zb = 1'b1;
      tick(1);
      chk(lc, `GFS_LOOP_CAL);
      chk({15'h0, flash}, 16'h0000);
      hv = 5'h01;
      tick(1);
      chk(lc, `GFS_LOOP_FAULT);
      {hv, zb, sb} = 7'h01;
      tick(1);
      chk(st, 16'h4000);
      sb = 1'b0;
      conc = 16'sh0032;
      tick(1);
      chk(lc, 16'h04b0);
      conc = 16'sh0000;
   endtask
   task t_health;
      for (int i = 0; i < 5; i++) begin
         hv = 5'h01 << i;
         tick(2);
         chk(rx_p, 16'h0001 | (16'h0001 << hb[i]));
         chk({15'h0, rx_f}, 16'h0001);
         hv = 5'h00;
         tick(1);
         chk(st, 16'h0000);
      end
   endtask
   task t_limits;
      logic [15:0] v[4] = '{16'h047d, 16'h047e, 16'h0af1, 16'h0af0};
      logic [15:0] t[4] = '{16'hffd7, 16'hffd8, 16'h004c, 16'h004b};
      for (int i = 0; i < 4; i++) begin
         sup = v[i];
         tick(1);
         chk(lc, i % 2 ? 16'h0190 : 16'h0000);
      end
      for (int i = 0; i < 4; i++) begin
         temp = t[i];
         tick(1);
         chk(st, i % 2 ? 16'h0000 : 16'h0005);
         chk(lc, 16'h0190);
      end
   endtask
   task t_span;
      for (int j = 0; j < 3; j++) begin
         pv = 3'h1 << j;
         tick(1);
         pv = 3'h0;
         tick(3);
         chk(st, 16'h0001 | (16'h0080 << j));
         chk(lc, 16'h0000);
         do_span(16'h0032);
         chk(st, 16'h0000);
      end
      chk({8'h0, life}, 16'h0032);
      do_span(16'h00c8);
      chk({8'h0, life}, 16'h0064);
      // life scales with the reference gain
      gref = 16'h00c8;
      do_span(16'h0064);
      chk({8'h0, life}, 16'h0032);
      gref = 16'h0064;
      // mid-run reset brings life back to full scale
      i_rst_n = 1'b0;
      tick(2);
      chk({8'h0, life}, 16'h0064);
      i_rst_n = 1'b1;
      tick(1);
      chk(lc, `GFS_LOOP_ZERO_SCALE);
   endtask
   task t_zero;
      conc = 16'shfff6;
      tick(1);
      chk(st, 16'h0000);
      conc = 16'shfff5;
      tick(1);
      conc = 16'sh0000;
      tick(3);
      chk(st, 16'h0801);
      zok = 1'b1;
      tick(1);
      zok = 1'b0;
      tick(1);
      chk(st, 16'h0000);
   endtask
   task t_days;
      do_span(16'h0064);
      tick(179 * DAYC + DAYC / 2);
      chk(days, 16'h00b3);
      chk(st, 16'h0000);
      wait_val(2, 16'h0002, 16'h0002);
      chk(days, `GFS_REMIND_DAYS);
      chk(lc, 16'h0190);
      do_span(16'h0064);
      chk(st, 16'h0000);
   endtask
   task t_display;
      hv = 5'h02;
      temp = 16'sh004c;
      wait_val(0, 16'h0001, 16'h0003);
      mag = 1'b1;
      tick(15);
      chk({14'h0, mode}, 16'h0001);
      wait_val(0, 16'h0002, 16'h0003);
      mag = 1'b0;
      chk({12'h0, idx}, 16'h0002);
      wait_val(1, 16'h0005, 16'h000f);
      wait_val(0, 16'h0000, 16'h0003);
      wait_val(0, 16'h0001, 16'h0003);
      chk(st, 16'h0025);
      // message stands five seconds, then normal display returns
      tick(99);
      chk({14'h0, mode}, 16'h0001);
      tick(1);
      chk({14'h0, mode}, 16'h0000);
      hv = 5'h00;
      temp = 16'sh0019;
   endtask
   // reset, then each scenario in turn
   initial begin
      {zb, sb, zok, sok, mag, hv, pv} = 13'h0;
      {conc, temp, gain} = 48'h0;
      fs = 16'h0064;
      gref = 16'h0064;
      sup = 16'h0960;
      i_rst_n = 1'b0;
      tick(12);
      i_rst_n = 1'b1;
      tick(1);
      chk({8'h0, life}, 16'h0064);
      chk(lc, `GFS_LOOP_ZERO_SCALE);
      t_levels();
      t_health();
      t_limits();
      t_span();
      t_zero();
      t_days();
      t_display();
      give_verdict();
   end
endmodule
`default_nettype wire
